// File: rtl/scp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module scp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic [WIDTH-1:0] s_data,
  input wire logic s_valid,
  output logic s_ready,
  // Drain side
  output logic [WIDTH-1:0] m_data,
  output logic m_valid,
  input wire logic m_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("scp_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;

  // Handshakes complete on registered flags
  assign push = s_valid & s_ready;
  assign pop = m_valid & m_ready;
  assign m_data = mem_r[rd_ptr_r];

  // Occupancy after this cycle
  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= s_data;
  end

  // Pointers, count and honest full/empty flags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      s_ready <= 1'b0;
      m_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_nxt;
      s_ready <= (count_nxt != (AW + 1)'(DEPTH));
      m_valid <= (count_nxt != '0);
    end
  end
endmodule

// File: rtl/scp_pkg.sv
// Constants shared by the serial configuration port and its data path
package scp_pkg;
  // ----------------------------------------------------------------
  // Word and latch layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int NUM_LATCH = 16;
  localparam int CTRL_W = 4;
  localparam logic [31:0] LATCH_RST = 32'h0000_0000;
  // Mode selection fields
  localparam int UART_BIT_POS = 28;
  localparam int SPI_SEL_LSB = 17;
  localparam int SPI_SEL_MSB = 19;
  localparam logic [2:0] SPI_SEL_CODE = 3'h7;
  localparam logic [3:0] MODE_LATCH = 4'h0;
  localparam logic [3:0] SPI_LATCH = 4'hF;
  // Readback setup latch and its source field
  localparam logic [3:0] RB_LATCH = 4'h7;
  localparam int RB_SRC_LSB = 4;
  localparam int RB_W = 16;
  localparam logic [1:0] RB_SRC_AFC = 2'h0;
  localparam logic [1:0] RB_SRC_ADC = 2'h1;
  // Sync word latch and field
  localparam logic [3:0] SYNC_LATCH = 4'hB;
  localparam int SYNC_LSB = 4;
  localparam int SYNC_W = 24;
  // ----------------------------------------------------------------
  // Clock dividers (half periods in 25 MHz cycles) and FIFO depth
  // ----------------------------------------------------------------
  localparam int DATA_HALF_DEF = 4;
  localparam int REF_HALF_DEF = 2;
  localparam int FIFO_DEPTH_DEF = 4;
endpackage

// File: rtl/scp_top.sv
// Serial configuration port with latch bank, readback and data mode pins
// Operation
// - Latch zero bit 28 selects UART mode
// - SPI needs UART bit and field seven
// - Data clock on divided output in UART/SPI
// - Chip enable low clears latches, shifters, dividers and sync; FIFO contents and tx_bit are kept
// - Load edge copies word to selected latch
// - Serial bit captured on serial clock rise
// - One readback bit per serial clock
// - Sync detect asserted on sync word match
// - Data I/O pin direction follows rx/tx mode, data clock pin direction follows UART mode
`timescale 1ns/1ps
module scp_top
  import scp_pkg::*;
#(
  parameter int DATA_HALF = scp_pkg::DATA_HALF_DEF,
  parameter int REF_HALF = scp_pkg::REF_HALF_DEF,
  parameter int FIFO_DEPTH = scp_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host serial port
  input wire logic chip_enable,
  input wire logic serial_clk,
  input wire logic config_serial_in,
  input wire logic latch_load_strobe,
  output logic readback_serial_out,
  // Radio side status and received bits
  input wire logic tx_mode,
  input wire logic [15:0] afc_value,
  input wire logic [6:0] adc_value,
  input wire logic rx_bit,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic tx_bit,
  // Data pins
  output logic divided_ref_output,
  output logic data_clock_pin_o,
  output logic data_clock_pin_oe,
  input wire logic data_clock_pin_i,
  output logic data_io_pin_o,
  output logic data_io_pin_oe,
  input wire logic data_io_pin_i,
  output logic sync_detect,
  // Mode status
  output logic uart_mode,
  output logic spi_mode
);
  generate
    if (DATA_HALF < 1 || REF_HALF < 1 || DATA_HALF > 65535 || REF_HALF > 65535)
    begin : g_bad_div
      $error("scp_top divider half periods must be 1 to 65535");
    end
  endgenerate
  // ----------------------------------------------------------------
  // Host serial port
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] latch_r [NUM_LATCH];
  logic sclk_d_r;
  logic load_d_r;
  logic sclk_rise;
  logic load_rise;
  logic [RB_W-1:0] rb_shift_r;
  logic [CTRL_W-1:0] sel;
  logic [RB_W-1:0] rb_src;
  assign sclk_rise = serial_clk & ~sclk_d_r;
  assign load_rise = latch_load_strobe & ~load_d_r;
  assign sel = shift_r[CTRL_W-1:0];
  // Edge history of host strobes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_d_r <= 1'b0;
      load_d_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= serial_clk;
      load_d_r <= latch_load_strobe;
    end
  end
  // Shift register, MSB first so select bits end up lowest
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      shift_r <= LATCH_RST;
    else if (!chip_enable)
      shift_r <= LATCH_RST;
    else if (sclk_rise)
      shift_r <= {shift_r[WORD_W-2:0], config_serial_in};
  end
  // Latch bank, written on the load edge and cleared while chip enable is low
  generate
    for (genvar gi = 0; gi < NUM_LATCH; gi++)
    begin : g_latch
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          latch_r[gi] <= LATCH_RST;
        else if (!chip_enable)
          latch_r[gi] <= LATCH_RST;
        else if (load_rise && sel == CTRL_W'(gi))
          latch_r[gi] <= shift_r;
      end
    end
  endgenerate
  // Readback source chosen by the word loaded into the readback latch
  always_comb
  begin
    unique case (shift_r[RB_SRC_LSB+1:RB_SRC_LSB])
      RB_SRC_AFC: rb_src = afc_value;
      RB_SRC_ADC: rb_src = {9'h0_00, adc_value};
      default: rb_src = {14'h0_000, spi_mode, uart_mode};
    endcase
  end
  // Readback shifter, one bit per serial clock rise
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rb_shift_r <= '0;
    else if (!chip_enable)
      rb_shift_r <= '0;
    else if (load_rise && sel == RB_LATCH)
      rb_shift_r <= rb_src;
    else if (sclk_rise)
      rb_shift_r <= {rb_shift_r[RB_W-2:0], 1'b0};
  end

  // Registered readback pin and mode flags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      readback_serial_out <= 1'b0;
      uart_mode <= 1'b0;
      spi_mode <= 1'b0;
    end
    else
    begin
      readback_serial_out <= rb_shift_r[RB_W-1];
      uart_mode <= latch_r[MODE_LATCH][UART_BIT_POS];
      spi_mode <= latch_r[MODE_LATCH][UART_BIT_POS]
        && latch_r[SPI_LATCH][SPI_SEL_MSB:SPI_SEL_LSB] == SPI_SEL_CODE;
    end
  end

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  logic [15:0] data_cnt_r;
  logic [15:0] ref_cnt_r;
  logic data_clk_r;
  logic ref_clk_r;
  logic data_fall;
  logic data_rise;
  assign data_fall = data_clk_r && data_cnt_r == 16'(DATA_HALF - 1);
  assign data_rise = !data_clk_r && data_cnt_r == 16'(DATA_HALF - 1);
  // Data clock and divided reference, both stopped while powered down
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_cnt_r <= '0;
      ref_cnt_r <= '0;
      data_clk_r <= 1'b0;
      ref_clk_r <= 1'b0;
    end
    else if (!chip_enable)
    begin
      data_cnt_r <= '0;
      ref_cnt_r <= '0;
      data_clk_r <= 1'b0;
      ref_clk_r <= 1'b0;
    end
    else
    begin
      data_cnt_r <= (data_cnt_r == 16'(DATA_HALF - 1)) ? 16'h0000 : data_cnt_r + 16'h0001;
      ref_cnt_r <= (ref_cnt_r == 16'(REF_HALF - 1)) ? 16'h0000 : ref_cnt_r + 16'h0001;
      if (data_cnt_r == 16'(DATA_HALF - 1))
        data_clk_r <= ~data_clk_r;
      if (ref_cnt_r == 16'(REF_HALF - 1))
        ref_clk_r <= ~ref_clk_r;
    end
  end

  // Divided output carries data clock in UART/SPI mode
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      divided_ref_output <= 1'b0;
    else
      divided_ref_output <= uart_mode ? data_clk_r : ref_clk_r;
  end

  // ----------------------------------------------------------------
  // Receive path through FIFO, sync search, transmit capture
  // ----------------------------------------------------------------
  logic fifo_bit;
  logic fifo_valid;
  logic fifo_pop;
  logic [SYNC_W-1:0] rx_hist_r;
  logic [SYNC_W-1:0] rx_hist_nxt;
  assign fifo_pop = data_fall & ~tx_mode & chip_enable;
  assign rx_hist_nxt = {rx_hist_r[SYNC_W-2:0], fifo_bit};
  scp_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rstn(rstn),
    .s_data(rx_bit),
    .s_valid(rx_valid & chip_enable),
    .s_ready(rx_ready),
    .m_data(fifo_bit),
    .m_valid(fifo_valid),
    .m_ready(fifo_pop)
  );

  // Received bit presented on falling data clock; sync word search
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_io_pin_o <= 1'b0;
      rx_hist_r <= '0;
      sync_detect <= 1'b0;
    end
    else if (!chip_enable)
    begin
      data_io_pin_o <= 1'b0;
      rx_hist_r <= '0;
      sync_detect <= 1'b0;
    end
    else if (fifo_pop && fifo_valid)
    begin
      data_io_pin_o <= fifo_bit;
      rx_hist_r <= rx_hist_nxt;
      sync_detect <= (rx_hist_nxt == latch_r[SYNC_LATCH][SYNC_LSB+SYNC_W-1:SYNC_LSB]);
    end
  end

  // Pin directions and transmit bit sampling
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_io_pin_oe <= 1'b0;
      data_clock_pin_oe <= 1'b0;
      data_clock_pin_o <= 1'b0;
      tx_bit <= 1'b0;
    end
    else
    begin
      data_io_pin_oe <= chip_enable & ~tx_mode;
      data_clock_pin_oe <= chip_enable & ~uart_mode;
      data_clock_pin_o <= data_clk_r;
      if (chip_enable && tx_mode && data_rise)
        tx_bit <= uart_mode ? data_clock_pin_i : data_io_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  mode_uart_a: assert property (chip_enable ##1 chip_enable |-> uart_mode == $past(latch_r[MODE_LATCH][UART_BIT_POS]))
    else $error("uart mode does not follow latch zero bit");
  mode_spi_a: assert property (spi_mode |-> uart_mode)
    else $error("spi mode without uart bit");
  divided_ref_output_mux_a: assert property (uart_mode |=> divided_ref_output == $past(data_clk_r))
    else $error("divided output not carrying data clock");
  ce_clear_a: assert property (!chip_enable |=> shift_r == '0 && latch_r[0] == '0 && latch_r[15] == '0)
    else $error("power down did not clear state");
  latch_load_a: assert property (chip_enable && load_rise |=> latch_r[$past(sel)] == $past(shift_r))
    else $error("load edge did not copy word");
  shift_in_a: assert property (chip_enable && sclk_rise |=> shift_r[0] == $past(config_serial_in))
    else $error("serial bit not captured");
  latch_hold_a: assert property (chip_enable && !load_rise |=> latch_r[3] == $past(latch_r[3]))
    else $error("latch changed without load edge");
  readback_bit_a: assert property (chip_enable && sclk_rise && !load_rise ##1 chip_enable |=>
    readback_serial_out == $past(rb_shift_r[RB_W-2], 2)) else $error("readback bit not advanced");
  pin_dir_a: assert property (chip_enable && uart_mode && !tx_mode |=> data_io_pin_oe && !data_clock_pin_oe)
    else $error("data pin direction wrong in receive");
  sync_hold_a: assert property (sync_detect && !(fifo_pop && fifo_valid) && chip_enable |=> sync_detect)
    else $error("sync detect dropped without new bit");
  load_seen_c: cover property (chip_enable && load_rise && sel == MODE_LATCH);
  spi_seen_c: cover property (spi_mode);
  sync_seen_c: cover property (sync_detect);
  fifo_full_c: cover property (!rx_ready && rx_valid);
endmodule

// File: verification/scp_host_model.sv
// Host microcontroller model driving the serial configuration port
`timescale 1ns/1ps
module scp_host_model (
  // Clock
  input wire logic clk,
  // Serial port
  output logic serial_clk,
  output logic config_serial_in,
  output logic latch_load_strobe,
  input wire logic readback_serial_out,
  // Receive status
  input wire logic sync_detect
);
  logic sync_seen_r = 1'b0;
  int sync_rise_cnt = 0;

  // ----------------------------------------------------------------
  // Serial words
  // ----------------------------------------------------------------
  initial
  begin
    serial_clk = 1'b0;
    config_serial_in = 1'b0;
    latch_load_strobe = 1'b0;
  end

  // One bit per rise, MSB first, select bits last
  task automatic shift_bits(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge clk) serial_clk <= 1'b0;
      config_serial_in <= w[i];
      @(negedge clk);
      @(negedge clk) serial_clk <= 1'b1;
      @(negedge clk);
    end
    @(negedge clk) serial_clk <= 1'b0;
  endtask

  // Whole word, then a load strobe
  task automatic write_word(input logic [31:0] w);
    shift_bits(w, 32);
    @(negedge clk) latch_load_strobe <= 1'b1;
    repeat (2) @(negedge clk);
    latch_load_strobe <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Sixteen readback bits, one serial clock each, MSB first
  task automatic read16(output logic [15:0] d);
    for (int i = 15; i >= 0; i--)
    begin
      d[i] = readback_serial_out;
      serial_clk <= 1'b1;
      repeat (2) @(negedge clk);
      serial_clk <= 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask

  // Each new sync detect rise is counted, sampled where settled
  always @(negedge clk)
  begin
    sync_seen_r <= sync_detect;
    if (sync_detect && !sync_seen_r)
      sync_rise_cnt <= sync_rise_cnt + 1;
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end
module testbench;
  import scp_pkg::*;
  localparam int DH = 4;
  localparam int RH = 2;
  localparam logic [23:0] SW = 24'hA5_3C96;
  logic clk = 1'b0, rstn, chip_enable, tx_mode;
  logic serial_clk, config_serial_in, latch_load_strobe, readback_serial_out;
  logic [15:0] afc_value;
  logic [6:0] adc_value;
  logic rx_bit, rx_valid, rx_ready, tx_bit, divided_ref_output, sync_detect;
  logic data_clock_pin_o, data_clock_pin_oe, data_clock_pin_i, data_io_pin_o, data_io_pin_oe, data_io_pin_i;
  logic dclk_drv = 1'b0, dio_drv = 1'b0, uart_mode, spi_mode, saw_full = 1'b0;
  logic [15:0] rb;
  int error_cnt = 0, n_compared = 0, cyc = 0, h;

  // ----------------------------------------------------------------
  // Clock, wires and timeout
  // ----------------------------------------------------------------
  always #20 clk = ~clk;
  assign data_clock_pin_i = data_clock_pin_oe ? data_clock_pin_o : dclk_drv;
  assign data_io_pin_i = data_io_pin_oe ? data_io_pin_o : dio_drv;
  always @(negedge clk)
  begin
    cyc++;
    if (rx_valid && rx_ready === 1'b0) saw_full <= 1'b1;
    if (cyc == 30000)
    begin
      error_cnt++;
      test_done();
    end
  end

  scp_top #(.DATA_HALF(DH), .REF_HALF(RH), .FIFO_DEPTH(4)) i_dut (.clk(clk), .rstn(rstn),
    .chip_enable(chip_enable), .serial_clk(serial_clk), .config_serial_in(config_serial_in),
    .latch_load_strobe(latch_load_strobe), .readback_serial_out(readback_serial_out), .tx_mode(tx_mode),
    .afc_value(afc_value), .adc_value(adc_value), .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_bit(tx_bit), .divided_ref_output(divided_ref_output), .data_clock_pin_o(data_clock_pin_o),
    .data_clock_pin_oe(data_clock_pin_oe), .data_clock_pin_i(data_clock_pin_i), .data_io_pin_o(data_io_pin_o),
    .data_io_pin_oe(data_io_pin_oe), .data_io_pin_i(data_io_pin_i), .sync_detect(sync_detect),
    .uart_mode(uart_mode), .spi_mode(spi_mode));

  scp_host_model i_host (.clk(clk), .serial_clk(serial_clk), .config_serial_in(config_serial_in),
    .latch_load_strobe(latch_load_strobe), .readback_serial_out(readback_serial_out), .sync_detect(sync_detect));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Cycles between two toggles of the divided output
  task automatic half_period(output int n);
    logic v;
    @(negedge clk) v = divided_ref_output;
    while (divided_ref_output === v && n_compared >= 0) @(negedge clk);
    v = divided_ref_output;
    n = 0;
    while (divided_ref_output === v && n < 100)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // One received bit into the FIFO, held until taken
  task automatic push_bit(input logic b);
    @(negedge clk) rx_bit <= b;
    rx_valid <= 1'b1;
    while (rx_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    chip_enable = 1'b0;
    tx_mode = 1'b0;
    rx_bit = 1'b0;
    rx_valid = 1'b0;
    afc_value = 16'hBEEF;
    adc_value = 7'h5A;
    repeat (5) @(negedge clk);
    rstn <= 1'b1;
    chip_enable <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK(uart_mode, 1'b0);
    `CHK(rx_ready, 1'b1);
    half_period(h);
    `CHK(h, RH);
    end_test("reset");
    // Mode selection, latch select and partial words
    i_host.write_word(32'h000E_000F);
    i_host.write_word(32'h1000_0001);
    `CHK(uart_mode, 1'b0);
    `CHK(spi_mode, 1'b0);
    i_host.write_word(32'h1000_0000);
    `CHK(uart_mode, 1'b1);
    `CHK(spi_mode, 1'b1);
    half_period(h);
    `CHK(h, DH);
    i_host.write_word(32'h000C_000F);
    `CHK(spi_mode, 1'b0);
    i_host.shift_bits(32'h0000_0000, 20);
    repeat (4) @(negedge clk);
    `CHK(uart_mode, 1'b1);
    end_test("modes");
    // Readback sources
    i_host.write_word(32'h0000_0007);
    i_host.read16(rb);
    `CHK(rb, 16'hBEEF);
    afc_value <= 16'h1357;
    adc_value <= 7'h25;
    i_host.write_word(32'h0000_0017);
    i_host.read16(rb);
    `CHK(rb, 16'h0025);
    i_host.write_word(32'h0000_0007);
    i_host.read16(rb);
    `CHK(rb, 16'h1357);
    i_host.write_word(32'h0000_0027);
    i_host.read16(rb);
    `CHK(rb, 16'h0001);
    end_test("readback");
    // Transmit in UART mode takes data from the clock pin
    tx_mode <= 1'b1;
    dclk_drv <= 1'b1;
    repeat (4 * DH) @(negedge clk);
    `CHK(data_clock_pin_oe, 1'b0);
    `CHK(data_io_pin_oe, 1'b0);
    `CHK(tx_bit, 1'b1);
    dclk_drv <= 1'b0;
    repeat (4 * DH) @(negedge clk);
    `CHK(tx_bit, 1'b0);
    // Power-down clears the mode latch, then transmit outside UART mode takes data from the I/O pin
    chip_enable <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK(uart_mode, 1'b0);
    chip_enable <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK(uart_mode, 1'b0);
    `CHK(data_clock_pin_oe, 1'b1);
    h = data_clock_pin_o;
    repeat (DH) @(negedge clk);
    `CHK(data_clock_pin_o, ~h[0]);
    dio_drv <= 1'b1;
    repeat (4 * DH) @(negedge clk);
    `CHK(tx_bit, 1'b1);
    end_test("power_down_tx");
    // Receive stream, FIFO fill and sync word match
    tx_mode <= 1'b0;
    i_host.write_word({4'h0, SW, 4'hB});
    for (int i = 23; i >= 0; i--) push_bit(SW[i]);
    @(negedge clk) rx_valid <= 1'b0;
    repeat (10 * 2 * DH) @(negedge clk);
    `CHK(saw_full, 1'b1);
    `CHK(sync_detect, 1'b1);
    `CHK(i_host.sync_rise_cnt, 1);
    `CHK(data_io_pin_oe, 1'b1);
    `CHK(data_io_pin_o, SW[0]);
    push_bit(1'b1);
    @(negedge clk) rx_valid <= 1'b0;
    repeat (4 * 2 * DH) @(negedge clk);
    `CHK(sync_detect, 1'b0);
    `CHK(data_io_pin_o, 1'b1);
    end_test("receive");
    test_done();
  end
endmodule
